/* File: logic/dms_pkg.sv */
package dms_pkg;

    // default operand width of one multiplier input
    localparam int DMS_OP_W = 18;
    // extra accumulator bits beyond two summed products
    localparam int DMS_GUARD_W = 4;
    // number of global clock, enable and reset sources
    localparam int DMS_NUM_SRC = 4;
    localparam int DMS_SEL_W = 2;

    // slice operating mode, one-hot
    typedef enum logic [1:0] {
        DMS_SINGLE_MULTIPLY_MODE = 2'h1,
        DMS_DUAL_MULTIPLY_ACCUMULATE_MODE = 2'h2
    } dms_mode_t;

    // per register stage: bypass and source selection
    typedef struct packed {
        logic bypass;
        logic [DMS_SEL_W-1:0] clk_sel;
        logic [DMS_SEL_W-1:0] ce_sel;
        logic [DMS_SEL_W-1:0] rst_sel;
    } dms_stage_cfg_t;

    // global fabric clock ticks, clock enables and resets
    typedef struct packed {
        logic [DMS_NUM_SRC-1:0] clk_src;
        logic [DMS_NUM_SRC-1:0] ce_src;
        logic [DMS_NUM_SRC-1:0] rst_src;
    } dms_fabric_t;

    // arithmetic flags, registered together with the result
    typedef struct packed {
        logic zero_match_flag;
        logic masked_zero_match_flag;
        logic masked_ones_match_flag;
        logic masked_pattern_match_flag;
        logic masked_inverted_pattern_match_flag;
        logic acc_overflow_flag;
        logic acc_underflow_flag;
        logic acc_limit_either_flag;
    } dms_flags_t;

    localparam dms_flags_t DMS_FLAGS_RST = '0;

endpackage

/* File: logic/dms_slice.sv */
// Contract
// - single mode outputs first product, no adder
// - single mode: each register stage optional
// - dual mode adds both products to accumulator
// - dual mode output register always holds sum
// - dual mode input, pipeline stages optional
// - overflow indication registered with accumulated value
// - zero, mask, pattern, overflow, underflow flags
// - each stage picks one of four clocks
// - each stage picks own enable and reset
module dms_slice #(
    parameter int OP_W = dms_pkg::DMS_OP_W,
    parameter int GUARD_W = dms_pkg::DMS_GUARD_W,
    parameter int ACC_W = 2 * OP_W + 1 + GUARD_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire dms_pkg::dms_mode_t mode_sel,
    input wire dms_pkg::dms_stage_cfg_t in_cfg,
    input wire dms_pkg::dms_stage_cfg_t pipe_cfg,
    input wire dms_pkg::dms_stage_cfg_t out_cfg,
    input wire dms_pkg::dms_fabric_t fab,
    input wire logic [OP_W-1:0] first_pair_operand_x,
    input wire logic [OP_W-1:0] first_pair_operand_y,
    input wire logic [OP_W-1:0] second_pair_operand_x,
    input wire logic [OP_W-1:0] second_pair_operand_y,
    input wire logic [ACC_W-1:0] match_mask,
    input wire logic [ACC_W-1:0] match_pattern,
    output logic [ACC_W-1:0] result_r,
    output dms_pkg::dms_flags_t flags_r
);
    import dms_pkg::*;

    localparam int IN_W = 4 * OP_W;
    localparam int PR_W = 2 * OP_W;
    localparam int SUM_W = ACC_W + 2;

    logic [IN_W-1:0] in_q;
    logic [2*PR_W-1:0] pipe_d;
    logic [2*PR_W-1:0] pipe_q;
    logic signed [OP_W-1:0] ax, ay, bx, by;
    logic signed [PR_W-1:0] prod0_c, prod1_c, p0, p1;
    logic signed [SUM_W-1:0] sum_wide;
    logic is_dual, transparent_out, out_edge, out_load, out_clr;
    logic acc_over, acc_under;
    logic [ACC_W-1:0] result_nxt;
    dms_flags_t flags_nxt;

    // input register stage, optional in both modes
    dms_stage #(.W(IN_W)) u_in_stage (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cfg(in_cfg),
        .fab(fab),
        .d({first_pair_operand_x, first_pair_operand_y,
            second_pair_operand_x, second_pair_operand_y}),
        .q(in_q)
    );

    // signed operand split and the two multipliers
    assign ax = $signed(in_q[4*OP_W-1 -: OP_W]);
    assign ay = $signed(in_q[3*OP_W-1 -: OP_W]);
    assign bx = $signed(in_q[2*OP_W-1 -: OP_W]);
    assign by = $signed(in_q[OP_W-1 -: OP_W]);
    assign prod0_c = ax * ay;
    assign prod1_c = bx * by;
    assign pipe_d = {prod0_c, prod1_c};

    // pipeline register stage on the products
    dms_stage #(.W(2 * PR_W)) u_pipe_stage (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cfg(pipe_cfg),
        .fab(fab),
        .d(pipe_d),
        .q(pipe_q)
    );

    assign p0 = $signed(pipe_q[2*PR_W-1 -: PR_W]);
    assign p1 = $signed(pipe_q[PR_W-1 -: PR_W]);

    // output stage control; dual mode never bypasses it
    assign is_dual = (mode_sel == DMS_DUAL_MULTIPLY_ACCUMULATE_MODE);
    assign transparent_out = !is_dual && out_cfg.bypass;
    assign out_edge = fab.clk_src[out_cfg.clk_sel];
    assign out_load = transparent_out || (out_edge && fab.ce_src[out_cfg.ce_sel]);
    assign out_clr = !transparent_out && out_edge && fab.rst_src[out_cfg.rst_sel];

    // accumulator sum with two spare bits for limit detection
    assign sum_wide = SUM_W'($signed(result_r)) + SUM_W'(p0) + SUM_W'(p1);
    assign acc_over = is_dual && !sum_wide[SUM_W-1]
        && (sum_wide[SUM_W-2:ACC_W-1] != '0);
    assign acc_under = is_dual && sum_wide[SUM_W-1]
        && (sum_wide[SUM_W-2:ACC_W-1] != '1);

    // next result: product alone, or wrapped accumulated sum
    assign result_nxt = is_dual ? sum_wide[ACC_W-1:0] : ACC_W'(p0);

    // flag evaluation on the value about to be stored; mask bit 1 ignores
    always_comb begin
        flags_nxt = DMS_FLAGS_RST;
        flags_nxt.zero_match_flag = (result_nxt == '0);
        flags_nxt.masked_zero_match_flag = ((result_nxt & ~match_mask) == '0);
        flags_nxt.masked_ones_match_flag = ((result_nxt | match_mask) == '1);
        flags_nxt.masked_pattern_match_flag =
            (((result_nxt ^ match_pattern) & ~match_mask) == '0);
        flags_nxt.masked_inverted_pattern_match_flag =
            (((result_nxt ^ ~match_pattern) & ~match_mask) == '0);
        flags_nxt.acc_overflow_flag = acc_over;
        flags_nxt.acc_underflow_flag = acc_under;
        flags_nxt.acc_limit_either_flag = acc_over || acc_under;
    end

    // output register: result and flags change on the same edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_r <= '0;
            flags_r <= DMS_FLAGS_RST;
        end else if (clk_en) begin
            if (out_clr) begin
                result_r <= '0;
                flags_r <= DMS_FLAGS_RST;
            end else if (out_load) begin
                result_r <= result_nxt;
                flags_r <= flags_nxt;
            end
        end
    end

    // checking helpers
    logic signed [ACC_W-1:0] chk_prod0;
    logic in_load_chk;
    assign chk_prod0 = ACC_W'(prod0_c);
    assign in_load_chk = fab.clk_src[in_cfg.clk_sel] & fab.ce_src[in_cfg.ce_sel]
        | fab.clk_src[in_cfg.clk_sel] & fab.rst_src[in_cfg.rst_sel];
    // wide reference sum; a stored value that differs from it has wrapped
    logic signed [ACC_W+1:0] chk_sum;
    assign chk_sum = (ACC_W+2)'($signed(result_r)) + (ACC_W+2)'(p0) + (ACC_W+2)'(p1);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_single_product;
        clk_en && !is_dual && in_cfg.bypass && pipe_cfg.bypass && out_cfg.bypass
        |=> result_r == $past(chk_prod0);
    endproperty
    a_single_product: assert property (p_single_product)
        else $error("single mode output is not the first product");

    property p_in_hold;
        clk_en && !in_cfg.bypass && !in_load_chk ##1 !in_cfg.bypass
        |-> $stable(in_q);
    endproperty
    a_in_hold: assert property (p_in_hold)
        else $error("input stage changed without its clock tick");

    property p_dual_sum;
        clk_en && is_dual && out_load && !out_clr && !acc_over && !acc_under
        |=> $signed(result_r) == $past($signed(result_r)) + $past(p0) + $past(p1);
    endproperty
    a_dual_sum: assert property (p_dual_sum)
        else $error("accumulated value is not old value plus both products");

    property p_dual_hold;
        is_dual && !(clk_en && out_edge) |=> $stable(result_r);
    endproperty
    a_dual_hold: assert property (p_dual_hold)
        else $error("accumulator changed without an output clock edge");

    // a registered pipeline stage captures the products on its own tick
    property p_pipe_load;
        clk_en && !pipe_cfg.bypass && fab.clk_src[pipe_cfg.clk_sel]
            && fab.ce_src[pipe_cfg.ce_sel] && !fab.rst_src[pipe_cfg.rst_sel]
            ##1 !pipe_cfg.bypass |-> pipe_q == $past(pipe_d);
    endproperty
    a_pipe_load: assert property (p_pipe_load)
        else $error("registered pipeline stage did not capture products");

    property p_over_registered;
        $rose(flags_r.acc_overflow_flag) |-> $past(clk_en && out_load && acc_over);
    endproperty
    a_over_registered: assert property (p_over_registered)
        else $error("overflow rose without a loading edge");

    property p_zero_flag;
        clk_en && out_load && !out_clr |=> flags_r.zero_match_flag == (result_r == '0);
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero match flag disagrees with result");

    property p_out_reset;
        clk_en && is_dual && out_edge && fab.rst_src[out_cfg.rst_sel]
        |=> result_r == '0 && flags_r == DMS_FLAGS_RST;
    endproperty
    a_out_reset: assert property (p_out_reset)
        else $error("selected output reset did not clear accumulator");

    property p_clk_select;
        clk_en && is_dual && !fab.clk_src[out_cfg.clk_sel] ##1 is_dual
        |-> $stable(result_r) && $stable(flags_r);
    endproperty
    a_clk_select: assert property (p_clk_select)
        else $error("output stage moved without its selected clock");

    property p_either_flag;
        clk_en && is_dual && out_load && !out_clr
        |=> flags_r.acc_limit_either_flag
            == ((ACC_W+2)'($signed(result_r)) != $past(chk_sum))
            && flags_r.acc_limit_either_flag
            == (flags_r.acc_overflow_flag || flags_r.acc_underflow_flag);
    endproperty
    a_either_flag: assert property (p_either_flag)
        else $error("combined limit flag mismatch");

    c_dual_overflow: cover property (clk_en && out_load && acc_over ##1 flags_r.acc_overflow_flag);
    c_dual_underflow: cover property (clk_en && out_load && acc_under);
    c_single_load: cover property (clk_en && !is_dual && out_load && p0 != '0);
    c_masked_pattern: cover property (flags_r.masked_pattern_match_flag
        && !flags_r.zero_match_flag);

endmodule // dms_slice

/* File: logic/dms_stage.sv */
module dms_stage #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire dms_pkg::dms_stage_cfg_t cfg,
    input wire dms_pkg::dms_fabric_t fab,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import dms_pkg::*;

    logic [W-1:0] hold_r;
    logic src_edge;
    logic src_load;
    logic src_clr;

    // selected clock source, enable and reset for this stage
    assign src_edge = fab.clk_src[cfg.clk_sel];
    assign src_load = src_edge & fab.ce_src[cfg.ce_sel];
    assign src_clr = src_edge & fab.rst_src[cfg.rst_sel];

    // stage register; reset on its own clock edge, not gated by enable
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hold_r <= '0;
        end else if (clk_en) begin
            if (src_clr) begin
                hold_r <= '0;
            end else if (src_load) begin
                hold_r <= d;
            end
        end
    end

    // bypassed stage passes data straight through
    assign q = cfg.bypass ? d : hold_r;

endmodule // dms_stage

/* File: verification/dms_fab_model.sv */
module dms_fab_model (
    input wire logic [dms_pkg::DMS_NUM_SRC-1:0] clk_mask,
    input wire logic [dms_pkg::DMS_NUM_SRC-1:0] ce_mask,
    input wire logic [dms_pkg::DMS_NUM_SRC-1:0] rst_mask,
    output dms_pkg::dms_fabric_t fab
);
    timeunit 1ns;
    timeprecision 1ps;
    import dms_pkg::*;
    // fabric logic hands its clock ticks, enables and resets to the slice
    assign fab = '{clk_src: clk_mask, ce_src: ce_mask, rst_src: rst_mask};
endmodule // dms_fab_model

/* File: verification/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dms_pkg::*;
    localparam int OW = 4;
    localparam int GW = 1;
    localparam int AW = 2 * OW + 1 + GW;
    localparam dms_stage_cfg_t BYP = '{bypass: 1'h1, default: '0};
    localparam dms_stage_cfg_t REG = '0;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic clk_en = 1'h1;
    dms_mode_t mode_sel = DMS_SINGLE_MULTIPLY_MODE;
    dms_stage_cfg_t in_cfg = BYP;
    dms_stage_cfg_t pipe_cfg = BYP;
    dms_stage_cfg_t out_cfg = BYP;
    logic [3:0] clk_mask = 4'hF;
    logic [3:0] ce_mask = 4'hF;
    logic [3:0] rst_mask = 4'h0;
    logic [OW-1:0] ax = '0, ay = '0, bx = '0, by = '0;
    logic [AW-1:0] match_mask = '0, match_pattern = '0;
    logic [AW-1:0] result_r;
    dms_fabric_t fab;
    dms_flags_t flags_r;
    int miscompares = 0;
    int cmp_count = 0;
    // clock at 125 MHz
    always #4 core_clk = ~core_clk;
    dms_fab_model dms_fab_model_inst (.clk_mask(clk_mask), .ce_mask(ce_mask),
        .rst_mask(rst_mask), .fab(fab));
    dms_slice #(.OP_W(OW), .GUARD_W(GW)) dms_slice_inst (.core_clk(core_clk),
        .rst_n(rst_n), .clk_en(clk_en), .mode_sel(mode_sel), .in_cfg(in_cfg),
        .pipe_cfg(pipe_cfg), .out_cfg(out_cfg), .fab(fab),
        .first_pair_operand_x(ax), .first_pair_operand_y(ay),
        .second_pair_operand_x(bx), .second_pair_operand_y(by),
        .match_mask(match_mask), .match_pattern(match_pattern),
        .result_r(result_r), .flags_r(flags_r));
    // signed product, sign-extended to accumulator width
    function automatic logic [AW-1:0] prod(logic [OW-1:0] a, logic [OW-1:0] b);
        int ai = $signed(a);
        int bi = $signed(b);
        return AW'(ai * bi);
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk_res(logic [AW-1:0] g, logic [AW-1:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_flag(logic g, logic e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic do_rst();
        rst_n = 1'h0;
        tick(1);
        rst_n = 1'h1;
    endtask
    // single multiply, every stage bypassed, sign corners
    task automatic t_single_bypass();
        logic [OW-1:0] xs[3] = '{4'h8, 4'h7, 4'h3};
        logic [OW-1:0] ys[3] = '{4'h8, 4'h8, 4'h5};
        mode_sel = DMS_SINGLE_MULTIPLY_MODE;
        bx = 4'h7;
        by = 4'h7;
        for (int i = 0; i < 3; i++) begin
            ax = xs[i];
            ay = ys[i];
            tick(1);
            chk_res(result_r, prod(xs[i], ys[i]));
        end
        $display("test single_bypass done");
    endtask
    // single multiply with input and pipeline stages in the path
    task automatic t_single_latency();
        in_cfg = REG;
        pipe_cfg = REG;
        ax = 4'h0;
        tick(4);
        ax = 4'h3;
        ay = 4'h5;
        tick(2);
        chk_res(result_r, '0);
        tick(1);
        chk_res(result_r, prod(4'h3, 4'h5));
        // no clock ticks: registered stages must hold their contents
        clk_mask = 4'h0;
        ax = 4'h1;
        tick(3);
        chk_res(result_r, prod(4'h3, 4'h5));
        clk_mask = 4'hF;
        in_cfg = BYP;
        pipe_cfg = BYP;
        $display("test single_latency done");
    endtask
    // dual mode accumulates both products; output bypass is ignored
    task automatic t_dual_acc();
        do_rst();
        mode_sel = DMS_DUAL_MULTIPLY_ACCUMULATE_MODE;
        {ax, ay, bx, by} = {4'h2, 4'h3, 4'h1, 4'hC};
        match_pattern = AW'(6);
        match_mask = AW'(10'h3F9);
        for (int k = 1; k <= 3; k++) begin
            tick(1);
            chk_res(result_r, AW'(2 * k));
        end
        chk_flag(flags_r.masked_pattern_match_flag, 1'h1);
        chk_flag(flags_r.masked_inverted_pattern_match_flag, 1'h0);
        chk_flag(flags_r.zero_match_flag, 1'h0);
        chk_flag(flags_r.masked_zero_match_flag, 1'h0);
        chk_flag(flags_r.masked_ones_match_flag, 1'h1);
        $display("test dual_acc done");
    endtask
    // wrap in both directions raises the registered limit flags
    task automatic t_overflow();
        do_rst();
        {ax, ay, bx, by} = {4'h8, 4'h8, 4'h8, 4'h8};
        for (int k = 1; k <= 3; k++) begin
            tick(1);
            chk_flag(flags_r.acc_overflow_flag, 1'h0);
        end
        tick(1);
        chk_res(result_r, AW'(512));
        chk_flag(flags_r.acc_overflow_flag, 1'h1);
        chk_flag(flags_r.acc_limit_either_flag, 1'h1);
        {ax, ay, bx, by} = {4'h7, 4'h8, 4'h7, 4'h8};
        tick(1);
        chk_res(result_r, AW'(-624));
        chk_flag(flags_r.acc_underflow_flag, 1'h1);
        chk_flag(flags_r.acc_overflow_flag, 1'h0);
        $display("test overflow done");
    endtask
    // output stage follows its own clock, enable and reset selections
    task automatic t_select();
        do_rst();
        out_cfg = '{bypass: 1'h0, clk_sel: 2'h2, ce_sel: 2'h1, rst_sel: 2'h3};
        {ax, ay, bx, by} = {4'h1, 4'h1, 4'h0, 4'h0};
        tick(1);
        chk_res(result_r, AW'(1));
        clk_mask = 4'hB;
        tick(2);
        chk_res(result_r, AW'(1));
        clk_mask = 4'hF;
        ce_mask = 4'hD;
        tick(2);
        chk_res(result_r, AW'(1));
        ce_mask = 4'hF;
        clk_en = 1'h0;
        tick(2);
        chk_res(result_r, AW'(1));
        clk_en = 1'h1;
        rst_mask = 4'h8;
        tick(1);
        chk_res(result_r, '0);
        chk_flag(flags_r.zero_match_flag, 1'h0);
        rst_mask = 4'h0;
        $display("test select done");
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog well beyond the roughly 40 cycles the tests need
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        tick(8);
        rst_n = 1'h1;
        t_single_bypass();
        t_single_latency();
        t_dual_acc();
        t_overflow();
        t_select();
        tally_and_finish();
    end
endmodule // tb
